// ### include/io_space_pkg.sv
// Package for the peripheral register space decoder: access kinds,
// address map, field masks and reset value.
// Assumes 8-bit data addresses, with I/O addresses offset into data space.

package io_space_pkg;

	// ------------------------------------------------------------
	// Access kinds issued by the core datapath
	// ------------------------------------------------------------
	typedef enum logic [7:0] {
		K_IO_READ = 8'h01,
		K_IO_WRITE = 8'h02,
		K_SET_IO_BIT = 8'h04,
		K_CLEAR_IO_BIT = 8'h08,
		K_SKIP_IF_IO_BIT_SET = 8'h10,
		K_SKIP_IF_IO_BIT_CLEAR = 8'h20,
		K_DATA_SPACE_LOAD = 8'h40,
		K_DATA_SPACE_WRITE = 8'h80
	} access_kind_t;

	// ------------------------------------------------------------
	// Space layout
	// ------------------------------------------------------------
	localparam logic [7:0] IO_DATA_OFFSET = 8'h20;
	localparam logic [7:0] EXT_FIRST = 8'h60;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int PORT_STRIDE = 3;
	localparam int SPACE_LAST = 255;

	// ------------------------------------------------------------
	// Register data-space addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_PORT_A_PIN_INPUT = 8'h20;
	localparam logic [7:0] ADDR_PORT_A_DIRECTION = 8'h21;
	localparam logic [7:0] ADDR_PORT_A_OUTPUT = 8'h22;
	localparam logic [7:0] ADDR_PORT_B_PIN_INPUT = 8'h23;
	localparam logic [7:0] ADDR_PORT_B_DIRECTION = 8'h24;
	localparam logic [7:0] ADDR_PORT_B_OUTPUT = 8'h25;
	localparam logic [7:0] ADDR_PORT_C_PIN_INPUT = 8'h26;
	localparam logic [7:0] ADDR_PORT_C_DIRECTION = 8'h27;
	localparam logic [7:0] ADDR_PORT_C_OUTPUT = 8'h28;
	localparam logic [7:0] ADDR_PORT_D_PIN_INPUT = 8'h29;
	localparam logic [7:0] ADDR_PORT_D_DIRECTION = 8'h2A;
	localparam logic [7:0] ADDR_PORT_D_OUTPUT = 8'h2B;
	localparam logic [7:0] ADDR_TIMER0_FLAGS = 8'h35;
	localparam logic [7:0] ADDR_TIMER1_FLAGS = 8'h36;
	localparam logic [7:0] ADDR_TIMER2_FLAGS = 8'h37;
	localparam logic [7:0] ADDR_TIMER3_FLAGS = 8'h38;
	localparam logic [7:0] ADDR_PIN_CHANGE_FLAGS = 8'h3B;
	localparam logic [7:0] ADDR_EXTERNAL_IRQ_FLAGS = 8'h3C;
	localparam logic [7:0] ADDR_EXTERNAL_IRQ_MASK = 8'h3D;
	localparam logic [7:0] ADDR_GENERAL_PURPOSE_0 = 8'h3E;
	localparam logic [7:0] ADDR_EEPROM_CONTROL = 8'h3F;
	localparam logic [7:0] ADDR_EEPROM_DATA = 8'h40;
	localparam logic [7:0] ADDR_EEPROM_ADDR_LOW = 8'h41;
	localparam logic [7:0] ADDR_EEPROM_ADDR_HIGH = 8'h42;
	localparam logic [7:0] ADDR_GENERAL_TIMER_CONTROL = 8'h43;
	localparam logic [7:0] ADDR_TIMER0_CONTROL_A = 8'h44;
	localparam logic [7:0] ADDR_TIMER0_CONTROL_B = 8'h45;
	localparam logic [7:0] ADDR_TIMER0_COUNT = 8'h46;
	localparam logic [7:0] ADDR_TIMER0_COMPARE_A = 8'h47;
	localparam logic [7:0] ADDR_TIMER0_COMPARE_B = 8'h48;
	localparam logic [7:0] ADDR_GENERAL_PURPOSE_1 = 8'h4A;
	localparam logic [7:0] ADDR_GENERAL_PURPOSE_2 = 8'h4B;
	localparam logic [7:0] ADDR_SERIAL_PERIPH_CONTROL = 8'h4C;
	localparam logic [7:0] ADDR_SERIAL_PERIPH_STATE = 8'h4D;
	localparam logic [7:0] ADDR_SERIAL_PERIPH_DATA = 8'h4E;
	localparam logic [7:0] ADDR_COMPARATOR_CONTROL = 8'h50;
	localparam logic [7:0] ADDR_DEBUG_DATA = 8'h51;
	localparam logic [7:0] ADDR_SLEEP_CONTROL = 8'h53;
	localparam logic [7:0] ADDR_RESET_CAUSE = 8'h54;
	localparam logic [7:0] ADDR_CORE_CONTROL = 8'h55;
	localparam logic [7:0] ADDR_SELF_PROGRAM_CONTROL = 8'h57;
	localparam logic [7:0] ADDR_STACK_POINTER_LOW = 8'h5D;
	localparam logic [7:0] ADDR_STACK_POINTER_HIGH = 8'h5E;
	localparam logic [7:0] ADDR_CORE_FLAGS = 8'h5F;
	localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'h60;
	localparam logic [7:0] ADDR_CLOCK_PRESCALE = 8'h61;
	localparam logic [7:0] ADDR_POWER_REDUCTION_0 = 8'h64;
	localparam logic [7:0] ADDR_POWER_REDUCTION_1 = 8'h65;

	// ------------------------------------------------------------
	// Attribute tables
	// ------------------------------------------------------------
	function automatic logic reg_is_pin(input logic [7:0] a);
		return a == ADDR_PORT_A_PIN_INPUT || a == ADDR_PORT_B_PIN_INPUT ||
			a == ADDR_PORT_C_PIN_INPUT || a == ADDR_PORT_D_PIN_INPUT;
	endfunction

	// Bits cleared by writing one; these are never plain-writable
	function automatic logic [7:0] reg_w1c(input logic [7:0] a);
		unique case (a)
			ADDR_TIMER0_FLAGS, ADDR_TIMER2_FLAGS, ADDR_EXTERNAL_IRQ_FLAGS: return 8'h07;
			ADDR_TIMER1_FLAGS, ADDR_TIMER3_FLAGS: return 8'h27;
			ADDR_PIN_CHANGE_FLAGS: return 8'h0F;
			default: return 8'h00;
		endcase
	endfunction

	// Plain-writable bits; reserved bits stay at reset value
	function automatic logic [7:0] reg_wmask(input logic [7:0] a);
		unique case (a)
			ADDR_PORT_A_DIRECTION, ADDR_PORT_A_OUTPUT, ADDR_PORT_B_DIRECTION,
			ADDR_PORT_B_OUTPUT, ADDR_PORT_C_DIRECTION, ADDR_PORT_C_OUTPUT,
			ADDR_PORT_D_DIRECTION, ADDR_PORT_D_OUTPUT, ADDR_GENERAL_PURPOSE_0,
			ADDR_EEPROM_DATA, ADDR_EEPROM_ADDR_LOW, ADDR_TIMER0_COUNT,
			ADDR_TIMER0_COMPARE_A, ADDR_TIMER0_COMPARE_B, ADDR_GENERAL_PURPOSE_1,
			ADDR_GENERAL_PURPOSE_2, ADDR_SERIAL_PERIPH_CONTROL, ADDR_SERIAL_PERIPH_DATA,
			ADDR_COMPARATOR_CONTROL, ADDR_DEBUG_DATA, ADDR_SELF_PROGRAM_CONTROL,
			ADDR_STACK_POINTER_LOW, ADDR_STACK_POINTER_HIGH, ADDR_CORE_FLAGS,
			ADDR_WATCHDOG_CONTROL, ADDR_POWER_REDUCTION_0: return 8'hFF;
			ADDR_EXTERNAL_IRQ_MASK: return 8'h07;
			ADDR_EEPROM_CONTROL: return 8'h3F;
			ADDR_EEPROM_ADDR_HIGH: return 8'h0F;
			ADDR_GENERAL_TIMER_CONTROL: return 8'h83;
			ADDR_TIMER0_CONTROL_A: return 8'hF3;
			ADDR_TIMER0_CONTROL_B: return 8'hCF;
			ADDR_SERIAL_PERIPH_STATE: return 8'hC1;
			ADDR_SLEEP_CONTROL: return 8'h0F;
			ADDR_RESET_CAUSE: return 8'h1F;
			ADDR_CORE_CONTROL: return 8'hF3;
			ADDR_CLOCK_PRESCALE: return 8'h8F;
			ADDR_POWER_REDUCTION_1: return 8'h01;
			default: return 8'h00;
		endcase
	endfunction

	function automatic logic reg_impl(input logic [7:0] a);
		return reg_is_pin(a) || reg_w1c(a) != 8'h00 || reg_wmask(a) != 8'h00;
	endfunction

endpackage

// ### verilog/io_space_decoder.sv
// Peripheral register space decoder: I/O and data-space access to
// the peripheral registers, with bit access in the low 32 I/O addresses.
// Assumes one request per cycle from the core datapath on clk; pins async.
//
// Function
// - Bit set and clear act on I/O addresses 0x00-0x1F only; others refused.
// - Skip-if-bit tests read any bit of I/O addresses 0x00-0x1F only.
// - Flag bits clear when written with one; a zero leaves them unchanged.
// - Bit set/clear rewrite whole register; flags read set are thereby cleared.
// - I/O read and write instructions use 6-bit I/O addresses 0x00-0x3F.
// - Data-space loads and writes see each register at I/O address plus 0x20.
// - Extended region 0x60-0xFF reachable only by data-space loads and writes.

`timescale 1ns/1ps
`default_nettype none

module io_space_decoder
	import io_space_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic acc_valid,
	input wire access_kind_t acc_kind,
	input wire logic [7:0] acc_addr,
	input wire logic [2:0] acc_bit,
	input wire logic [7:0] acc_wdata,
	output logic acc_done_q,
	output logic acc_refused_q,
	output logic [7:0] acc_rdata_q,
	output logic acc_skip_q,
	input wire logic [7:0] pin_a,
	input wire logic [7:0] pin_b,
	input wire logic [7:0] pin_c,
	input wire logic [7:0] pin_d,
	input wire logic [7:0] timer0_flag_set,
	input wire logic [7:0] timer1_flag_set,
	input wire logic [7:0] timer2_flag_set,
	input wire logic [7:0] timer3_flag_set,
	input wire logic [7:0] pin_change_flag_set,
	input wire logic [7:0] external_irq_flag_set,
	output logic [7:0] port_a_output,
	output logic [7:0] port_a_direction,
	output logic [7:0] port_b_output,
	output logic [7:0] port_b_direction,
	output logic [7:0] port_c_output,
	output logic [7:0] port_c_direction,
	output logic [7:0] port_d_output,
	output logic [7:0] port_d_direction
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [7:0] pin_s1_q [4];
	logic [7:0] pin_s2_q [4];
	logic [7:0] pin_raw [4];

	assign pin_raw[0] = pin_a;
	assign pin_raw[1] = pin_b;
	assign pin_raw[2] = pin_c;
	assign pin_raw[3] = pin_d;

	// Only the second stage is read; a pin change shows two edges late
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				pin_s1_q[i] <= REG_RESET;
				pin_s2_q[i] <= REG_RESET;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				pin_s1_q[i] <= pin_raw[i];
				pin_s2_q[i] <= pin_s1_q[i];
			end
		end
	end

	// ------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------
	logic is_io;
	logic is_bit_rw;
	logic is_skip;
	logic is_write;
	logic is_read;
	logic refused;
	logic mapped;
	logic [7:0] eff_addr;
	logic [7:0] bit_onehot;
	logic [7:0] rd_cur;
	logic [7:0] wr_val;
	logic wr_en;
	logic [7:0] cur [IO_DATA_OFFSET:SPACE_LAST];
	logic [7:0] hw_set [IO_DATA_OFFSET:SPACE_LAST];

	assign is_bit_rw = acc_kind == K_SET_IO_BIT || acc_kind == K_CLEAR_IO_BIT;
	assign is_skip = acc_kind == K_SKIP_IF_IO_BIT_SET || acc_kind == K_SKIP_IF_IO_BIT_CLEAR;
	assign is_io = is_bit_rw || is_skip || acc_kind == K_IO_READ || acc_kind == K_IO_WRITE;
	assign is_write = is_bit_rw || acc_kind == K_IO_WRITE || acc_kind == K_DATA_SPACE_WRITE;
	assign is_read = acc_kind == K_IO_READ || acc_kind == K_DATA_SPACE_LOAD;

	// I/O forms carry only a 6-bit address, so they can never reach
	// the extended region above the offset I/O window.
	assign eff_addr = is_io ? 8'({2'b00, acc_addr[5:0]} + IO_DATA_OFFSET)
		: acc_addr;
	assign refused = (is_io && acc_addr[7:6] != 2'b00)
		|| ((is_bit_rw || is_skip) && acc_addr[5]);
	assign mapped = reg_impl(eff_addr);
	assign bit_onehot = 8'h01 << acc_bit;
	assign rd_cur = mapped ? cur[eff_addr] : 8'h00;

	// Writes to unmapped or reserved addresses are dropped silently
	assign wr_en = acc_valid && !refused && is_write && mapped;

	// Bit forms rewrite the whole register from its read value, so
	// any flag that reads one, except the bit a clear addresses, is written one and clears.
	always_comb begin
		unique case (acc_kind)
			K_SET_IO_BIT: wr_val = rd_cur | bit_onehot;
			K_CLEAR_IO_BIT: wr_val = rd_cur & ~bit_onehot;
			default: wr_val = acc_wdata;
		endcase
	end

	// ------------------------------------------------------------
	// Hardware flag events
	// ------------------------------------------------------------
	always_comb begin
		for (int i = IO_DATA_OFFSET; i <= SPACE_LAST; i++) begin
			hw_set[i] = 8'h00;
		end
		hw_set[ADDR_TIMER0_FLAGS] = timer0_flag_set;
		hw_set[ADDR_TIMER1_FLAGS] = timer1_flag_set;
		hw_set[ADDR_TIMER2_FLAGS] = timer2_flag_set;
		hw_set[ADDR_TIMER3_FLAGS] = timer3_flag_set;
		hw_set[ADDR_PIN_CHANGE_FLAGS] = pin_change_flag_set;
		hw_set[ADDR_EXTERNAL_IRQ_FLAGS] = external_irq_flag_set;
	end

	// ------------------------------------------------------------
	// Register storage, one entry per data address
	// ------------------------------------------------------------
	for (genvar a = IO_DATA_OFFSET; a <= SPACE_LAST; a++) begin : g_space
		localparam logic [7:0] A = 8'(a);
		localparam logic [7:0] WM = reg_wmask(A);
		localparam logic [7:0] W1 = reg_w1c(A);
		if (reg_is_pin(A)) begin : g_pin
			assign cur[a] = pin_s2_q[(a - IO_DATA_OFFSET) / PORT_STRIDE];
		end else if (reg_impl(A)) begin : g_reg
			logic [7:0] q;
			// A hardware set in the clearing cycle wins over the clear
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					q <= REG_RESET;
				end else if (wr_en && eff_addr == A) begin
					q <= (((q & ~WM) | (wr_val & WM)) & ~(wr_val & W1)) | (hw_set[a] & W1);
				end else begin
					q <= q | (hw_set[a] & W1);
				end
			end
			assign cur[a] = q;
		end else begin : g_none
			assign cur[a] = 8'h00;
		end
	end

	assign port_a_output = cur[ADDR_PORT_A_OUTPUT];
	assign port_a_direction = cur[ADDR_PORT_A_DIRECTION];
	assign port_b_output = cur[ADDR_PORT_B_OUTPUT];
	assign port_b_direction = cur[ADDR_PORT_B_DIRECTION];
	assign port_c_output = cur[ADDR_PORT_C_OUTPUT];
	assign port_c_direction = cur[ADDR_PORT_C_DIRECTION];
	assign port_d_output = cur[ADDR_PORT_D_OUTPUT];
	assign port_d_direction = cur[ADDR_PORT_D_DIRECTION];

	// ------------------------------------------------------------
	// Answer registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_done_q <= 1'b0;
			acc_refused_q <= 1'b0;
		end else begin
			acc_done_q <= acc_valid;
			acc_refused_q <= acc_valid && refused;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_rdata_q <= REG_RESET;
		end else if (acc_valid && !refused && is_read) begin
			acc_rdata_q <= rd_cur;
		end else begin
			acc_rdata_q <= 8'h00;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_skip_q <= 1'b0;
		end else if (acc_valid && !refused && acc_kind == K_SKIP_IF_IO_BIT_SET) begin
			acc_skip_q <= rd_cur[acc_bit];
		end else if (acc_valid && !refused && acc_kind == K_SKIP_IF_IO_BIT_CLEAR) begin
			acc_skip_q <= !rd_cur[acc_bit];
		end else begin
			acc_skip_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	logic rd_bit;
	assign rd_bit = rd_cur[acc_bit];

	property p_bit_op_range;
		@(posedge clk) disable iff (!rst_n)
		acc_valid && is_bit_rw && acc_addr[5] |=> acc_refused_q && acc_done_q;
	endproperty
	a_bit_op_range: assert property (p_bit_op_range)
		else $error("bit op above 0x1F not refused");

	property p_bit_op_no_effect;
		@(posedge clk) disable iff (!rst_n)
		acc_valid && acc_kind == K_SET_IO_BIT && acc_addr == 8'h3E && acc_bit == 3'd0
		|=> $stable(cur[ADDR_STACK_POINTER_HIGH]);
	endproperty
	a_bit_op_no_effect: assert property (p_bit_op_no_effect)
		else $error("bit op above 0x1F changed a register");

	property p_skip_set;
		@(posedge clk) disable iff (!rst_n)
		acc_valid && acc_kind == K_SKIP_IF_IO_BIT_SET && !refused |=> acc_skip_q == $past(rd_bit);
	endproperty
	a_skip_set: assert property (p_skip_set)
		else $error("skip-if-set result wrong");

	property p_w1c;
		@(posedge clk) disable iff (!rst_n)
		acc_valid && acc_kind == K_DATA_SPACE_WRITE && acc_addr == ADDR_TIMER0_FLAGS
		&& timer0_flag_set == 8'h00
		|=> cur[ADDR_TIMER0_FLAGS] == ($past(cur[ADDR_TIMER0_FLAGS]) & ~$past(acc_wdata));
	endproperty
	a_w1c: assert property (p_w1c)
		else $error("flag write-one-to-clear wrong");

	property p_set_wins;
		@(posedge clk) disable iff (!rst_n)
		timer1_flag_set != 8'h00
		|=> (cur[ADDR_TIMER1_FLAGS] & $past(timer1_flag_set & 8'h27)) == $past(timer1_flag_set & 8'h27);
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("hardware flag set lost");

	property p_rmw_clears;
		@(posedge clk) disable iff (!rst_n)
		acc_valid && acc_kind == K_SET_IO_BIT && acc_addr == ADDR_TIMER0_FLAGS - IO_DATA_OFFSET
		&& timer0_flag_set == 8'h00 |=> cur[ADDR_TIMER0_FLAGS] == 8'h00;
	endproperty
	a_rmw_clears: assert property (p_rmw_clears)
		else $error("bit set did not clear flags read as set");

	property p_io_upper_refused;
		@(posedge clk) disable iff (!rst_n)
		acc_valid && is_io && acc_addr[7:6] != 2'b00 |=> acc_refused_q && acc_done_q;
	endproperty
	a_io_upper_refused: assert property (p_io_upper_refused)
		else $error("I/O address beyond 0x3F accepted");

	property p_io_offset;
		@(posedge clk) disable iff (!rst_n)
		acc_valid && acc_kind == K_IO_READ && acc_addr == ADDR_PORT_A_DIRECTION - IO_DATA_OFFSET
		|=> acc_rdata_q == $past(cur[ADDR_PORT_A_DIRECTION]);
	endproperty
	a_io_offset: assert property (p_io_offset)
		else $error("I/O address not offset by 0x20");

	property p_ext_data_only;
		@(posedge clk) disable iff (!rst_n)
		acc_valid && is_io |=> $stable(cur[ADDR_WATCHDOG_CONTROL]) && $stable(cur[ADDR_CLOCK_PRESCALE]);
	endproperty
	a_ext_data_only: assert property (p_ext_data_only)
		else $error("I/O form reached extended region");

	property p_unmapped_zero;
		@(posedge clk) disable iff (!rst_n)
		acc_valid && acc_kind == K_DATA_SPACE_LOAD && !mapped |=> acc_rdata_q == 8'h00;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero)
		else $error("unmapped read not zero");

	property p_done_timing;
		@(posedge clk) disable iff (!rst_n)
		acc_valid |=> acc_done_q;
	endproperty
	a_done_timing: assert property (p_done_timing)
		else $error("answer not one cycle after request");

	// Same-edge race: a hardware set must survive a write-one clear
	property p_flag_set_wins;
		@(posedge clk) disable iff (!rst_n)
		wr_en && eff_addr == ADDR_TIMER1_FLAGS && timer1_flag_set[0]
		|=> cur[ADDR_TIMER1_FLAGS][0];
	endproperty
	a_flag_set_wins: assert property (p_flag_set_wins)
		else $error("flag set lost to a simultaneous clear");

	property p_skip_clear;
		@(posedge clk) disable iff (!rst_n)
		acc_valid && acc_kind == K_SKIP_IF_IO_BIT_CLEAR && !refused
		|=> acc_skip_q == !$past(rd_bit);
	endproperty
	a_skip_clear: assert property (p_skip_clear)
		else $error("skip-if-clear result wrong");

	// Bit clear writes the addressed flag back as zero, so only it survives
	property p_clear_bit_keeps;
		@(posedge clk) disable iff (!rst_n)
		acc_valid && acc_kind == K_CLEAR_IO_BIT
		&& acc_addr == ADDR_EXTERNAL_IRQ_FLAGS - IO_DATA_OFFSET && external_irq_flag_set == 8'h00
		|=> cur[ADDR_EXTERNAL_IRQ_FLAGS] == ($past(rd_cur) & $past(bit_onehot));
	endproperty
	a_clear_bit_keeps: assert property (p_clear_bit_keeps)
		else $error("bit clear kept a flag read as set");

	property p_data_write_lands;
		@(posedge clk) disable iff (!rst_n)
		acc_valid && acc_kind == K_DATA_SPACE_WRITE && acc_addr == ADDR_PORT_A_OUTPUT
		|=> port_a_output == $past(acc_wdata);
	endproperty
	a_data_write_lands: assert property (p_data_write_lands)
		else $error("data-space write missed its register");

	property p_refused_quiet;
		@(posedge clk) disable iff (!rst_n)
		acc_refused_q |-> acc_rdata_q == 8'h00 && !acc_skip_q;
	endproperty
	a_refused_quiet: assert property (p_refused_quiet)
		else $error("refused access returned data or skip");

	property p_reserved_zero;
		@(posedge clk) disable iff (!rst_n)
		(cur[ADDR_CORE_CONTROL] & ~reg_wmask(ADDR_CORE_CONTROL)) == 8'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved bits read nonzero");

	// A pin level reaches the read path two edges after it is sampled
	property p_pin_two_stages;
		@(posedge clk) disable iff (!rst_n)
		1'b1 |-> ##2 cur[ADDR_PORT_A_PIN_INPUT] == $past(pin_a, 2);
	endproperty
	a_pin_two_stages: assert property (p_pin_two_stages)
		else $error("pin read not two stages behind the pin");

	c_io_write: cover property (@(posedge clk) disable iff (!rst_n)
		acc_valid && acc_kind == K_IO_WRITE && !refused);
	c_set_bit: cover property (@(posedge clk) disable iff (!rst_n)
		acc_valid && acc_kind == K_SET_IO_BIT && !refused ##1 acc_done_q);
	c_skip_taken: cover property (@(posedge clk) disable iff (!rst_n)
		acc_valid && is_skip ##1 acc_skip_q);
	c_ext_write: cover property (@(posedge clk) disable iff (!rst_n)
		acc_valid && acc_kind == K_DATA_SPACE_WRITE && acc_addr >= EXT_FIRST && mapped);
	c_flag_race: cover property (@(posedge clk) disable iff (!rst_n)
		wr_en && eff_addr == ADDR_TIMER1_FLAGS && timer1_flag_set != 8'h00);

endmodule

`default_nettype wire

// ### test/core_model.sv
// Core-side model: issues single accesses to the register space decoder.
// Assumes the answer is registered at the taking edge and read at the next falling edge.

`timescale 1ns/1ps
`default_nettype none

module core_model
	import io_space_pkg::*;
(
	input wire logic clk,
	output logic acc_valid,
	output access_kind_t acc_kind,
	output logic [7:0] acc_addr,
	output logic [2:0] acc_bit,
	output logic [7:0] acc_wdata,
	input wire logic acc_done_q,
	input wire logic acc_refused_q,
	input wire logic [7:0] acc_rdata_q,
	input wire logic acc_skip_q
);
	initial begin
		acc_valid = 1'b0;
		acc_kind = K_IO_READ;
		acc_addr = 8'h00;
		acc_bit = 3'h0;
		acc_wdata = 8'h00;
	end

	// --------------------------------------------------------------
	// One access
	// --------------------------------------------------------------
	// Callers pass only masked data to mapped addresses
	task automatic issue(input access_kind_t k, input logic [7:0] a, input logic [2:0] b,
		input logic [7:0] w, output logic [7:0] rd, output logic sk, output logic rf,
		output logic ok);
		@(negedge clk);
		acc_valid = 1'b1;
		acc_kind = k;
		acc_addr = a;
		acc_bit = b;
		acc_wdata = w;
		@(posedge clk);
		@(negedge clk);
		ok = acc_done_q;
		rf = acc_refused_q;
		rd = acc_rdata_q;
		sk = acc_skip_q;
		// Stale qualifiers would hide a decoder latching late
		acc_valid = 1'b0;
		acc_addr = ~a;
		acc_bit = ~b;
		acc_wdata = ~w;
	endtask
endmodule

`default_nettype wire

// ### test/tb_io_space_decoder.sv
// Self-checking bench for the register space decoder.
// Assumes core_model drives the access port; pins and flags driven here.

`timescale 1ns/1ps
`default_nettype none

module tb_io_space_decoder;
	import io_space_pkg::*;

	logic clk, rst_n, acc_valid, done, refused, skip, sk, rf, ok;
	access_kind_t acc_kind;
	logic [7:0] acc_addr, acc_wdata, rdata, rd;
	logic [2:0] acc_bit;
	logic [7:0] pin_a, pin_b, pin_c, pin_d, f0, f1, f2, f3, fpc, fex;
	logic [7:0] out_a, dir_a, out_b, dir_b, out_c, dir_c, out_d, dir_d;
	int errors, total_checks;

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	core_model u_core (.clk(clk), .acc_valid(acc_valid), .acc_kind(acc_kind),
		.acc_addr(acc_addr), .acc_bit(acc_bit), .acc_wdata(acc_wdata),
		.acc_done_q(done), .acc_refused_q(refused), .acc_rdata_q(rdata),
		.acc_skip_q(skip));

	io_space_decoder u_dut (.clk(clk), .rst_n(rst_n), .acc_valid(acc_valid),
		.acc_kind(acc_kind), .acc_addr(acc_addr), .acc_bit(acc_bit),
		.acc_wdata(acc_wdata), .acc_done_q(done), .acc_refused_q(refused),
		.acc_rdata_q(rdata), .acc_skip_q(skip), .pin_a(pin_a), .pin_b(pin_b),
		.pin_c(pin_c), .pin_d(pin_d), .timer0_flag_set(f0), .timer1_flag_set(f1),
		.timer2_flag_set(f2), .timer3_flag_set(f3), .pin_change_flag_set(fpc),
		.external_irq_flag_set(fex), .port_a_output(out_a), .port_a_direction(dir_a),
		.port_b_output(out_b), .port_b_direction(dir_b), .port_c_output(out_c),
		.port_c_direction(dir_c), .port_d_output(out_d), .port_d_direction(dir_d));

	// --------------------------------------------------------------
	// Compare and access helpers
	// --------------------------------------------------------------
	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk1(input string n, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %b seen %b", n, e, g);
		end
	endtask

	task automatic acc(input access_kind_t k, input logic [7:0] a, input logic [2:0] b,
		input logic [7:0] w, input logic er);
		u_core.issue(k, a, b, w, rd, sk, rf, ok);
		chk1("done", 1'b1, ok);
		chk1("refused", er, rf);
		if (er) chk8("refused_rdata", 8'h00, rd);
	endtask

	task automatic ld(input logic [7:0] a, input logic [7:0] e);
		acc(K_DATA_SPACE_LOAD, a, 3'h0, 8'h00, 1'b0);
		chk8("load", e, rd);
	endtask

	task automatic st(input logic [7:0] a, input logic [7:0] w);
		acc(K_DATA_SPACE_WRITE, a, 3'h0, w, 1'b0);
	endtask

	task automatic flags(input logic [7:0] v);
		@(negedge clk);
		{f0, f1, f2, f3, fpc, fex} = {6{v}};
		@(negedge clk);
		{f0, f1, f2, f3, fpc, fex} = '0;
	endtask

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic t_reset();
		for (int i = 0; i < 256; i++) ld(i[7:0], 8'h00);
		chk8("out_a", 8'h00, out_a);
	endtask

	task automatic t_mask();
		logic [7:0] ad[8] = '{8'h3D, 8'h3F, 8'h42, 8'h43, 8'h55, 8'h61, 8'h65, 8'h44};
		logic [7:0] mk[8] = '{8'h07, 8'h3F, 8'h0F, 8'h83, 8'hF3, 8'h8F, 8'h01, 8'hF3};
		for (int i = 0; i < 8; i++) begin
			st(ad[i], mk[i]);
			ld(ad[i], mk[i]);
			st(ad[i], mk[i] & 8'h55);
			ld(ad[i], mk[i] & 8'h55);
		end
	endtask

	task automatic t_map();
		logic [7:0] io[8] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h0B};
		logic [7:0] v;
		for (int i = 0; i < 8; i++) begin
			v = {io[i][3:0], ~io[i][3:0]};
			acc(K_IO_WRITE, io[i], 3'h0, v, 1'b0);
			ld(io[i] + 8'h20, v);
			acc(K_IO_READ, io[i], 3'h0, 8'h00, 1'b0);
			chk8("io_read", v, rd);
		end
		chk8("out_d", 8'hB4, out_d);
		chk8("dir_c", 8'h78, dir_c);
		chk8("dir_a", 8'h1E, dir_a);
		chk8("out_b", 8'h5A, out_b);
		chk8("dir_b", 8'h4B, dir_b);
		chk8("out_c", 8'h87, out_c);
		chk8("dir_d", 8'hA5, dir_d);
		acc(K_IO_WRITE, 8'h3F, 3'h0, 8'hC3, 1'b0);
		ld(8'h5F, 8'hC3);
		acc(K_IO_READ, 8'h40, 3'h0, 8'h00, 1'b1);
	endtask

	task automatic t_ext();
		st(8'h61, 8'h85);
		acc(K_IO_READ, 8'h61, 3'h0, 8'h00, 1'b1);
		acc(K_IO_WRITE, 8'h61, 3'h0, 8'h0A, 1'b1);
		ld(8'h61, 8'h85);
	endtask

	task automatic t_bits();
		logic [7:0] e;
		st(8'h22, 8'h00);
		e = 8'h00;
		for (int i = 0; i < 8; i++) begin
			acc(K_SET_IO_BIT, 8'h02, i[2:0], 8'h00, 1'b0);
			e[i] = 1'b1;
			chk8("out_a", e, out_a);
		end
		for (int i = 0; i < 8; i += 2) acc(K_CLEAR_IO_BIT, 8'h02, i[2:0], 8'h00, 1'b0);
		chk8("out_a", 8'hAA, out_a);
		acc(K_SET_IO_BIT, 8'h1F, 3'h5, 8'h00, 1'b0);
		ld(8'h3F, 8'h35);
		acc(K_SET_IO_BIT, 8'h3E, 3'h0, 8'h00, 1'b1);
		acc(K_CLEAR_IO_BIT, 8'h20, 3'h0, 8'h00, 1'b1);
		ld(8'h5E, 8'h00);
	endtask

	task automatic t_skip();
		for (int i = 0; i < 8; i++) begin
			acc(K_SKIP_IF_IO_BIT_SET, 8'h02, i[2:0], 8'h00, 1'b0);
			chk1("skip_set", i[0], sk);
			acc(K_SKIP_IF_IO_BIT_CLEAR, 8'h02, i[2:0], 8'h00, 1'b0);
			chk1("skip_clear", ~i[0], sk);
		end
		acc(K_SKIP_IF_IO_BIT_SET, 8'h20, 3'h1, 8'h00, 1'b1);
		chk1("skip_refused", 1'b0, sk);
	endtask

	task automatic t_flags();
		flags(8'hFF);
		ld(8'h35, 8'h07);
		ld(8'h36, 8'h27);
		ld(8'h3B, 8'h0F);
		st(8'h35, 8'h02);
		ld(8'h35, 8'h05);
		acc(K_IO_WRITE, 8'h15, 3'h0, 8'h00, 1'b0);
		ld(8'h35, 8'h05);
		acc(K_SET_IO_BIT, 8'h15, 3'h1, 8'h00, 1'b0);
		ld(8'h35, 8'h00);
		acc(K_CLEAR_IO_BIT, 8'h16, 3'h5, 8'h00, 1'b0);
		ld(8'h36, 8'h20);
		acc(K_CLEAR_IO_BIT, 8'h1C, 3'h0, 8'h00, 1'b0);
		ld(8'h3C, 8'h01);
		ld(8'h38, 8'h27);
		f1 = 8'h01;
		st(8'h36, 8'h21);
		f1 = 8'h00;
		ld(8'h36, 8'h01);
	endtask

	task automatic t_pins();
		@(negedge clk);
		{pin_a, pin_b, pin_c, pin_d} = 32'h5AC3_3C96;
		repeat (3) @(negedge clk);
		ld(8'h20, 8'h5A);
		ld(8'h29, 8'h96);
		acc(K_IO_READ, 8'h06, 3'h0, 8'h00, 1'b0);
		chk8("pin_c", 8'h3C, rd);
		st(8'h23, 8'h00);
		ld(8'h23, 8'hC3);
	endtask

	task automatic t_rerst();
		@(negedge clk);
		rst_n = 1'b0;
		@(negedge clk);
		chk8("out_a", 8'h00, out_a);
		rst_n = 1'b1;
		ld(8'h22, 8'h00);
	endtask

	// --------------------------------------------------------------
	// Run control
	// --------------------------------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		#1_000_000;
		errors++;
		summarize();
	end

	initial begin
		errors = 0;
		total_checks = 0;
		rst_n = 1'b0;
		{pin_a, pin_b, pin_c, pin_d} = '0;
		{f0, f1, f2, f3, fpc, fex} = '0;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		t_reset();
		t_mask();
		t_map();
		t_ext();
		t_bits();
		t_skip();
		t_flags();
		t_pins();
		t_rerst();
		summarize();
	end
endmodule

`default_nettype wire
